// File: hdl/hppsl_pkg.sv
// Behaviour
// - straps are captured at power-on reset and again when the external reset pin rises, then held.
// - a downstream port is disabled when its D+ strap and its D- strap are both sampled high.
// - a power control pin used as output is driven high for power on and low for power off.
// - a power control pin used as input reads low as an overcurrent from the external monitor.
// - a high shared-power strap on the port 4 pin selects ganged mode with port 4 as common control.
// - the upstream power-detect input decides whether the hub presents itself upstream.
// - toggling upstream power-detect renegotiates the upstream link without a chip reset.
package hppsl_pkg;

  // ************************************************************
  // sizes and timing
  // ************************************************************
  localparam int unsigned PORT_CNT        = 4;
  localparam int unsigned CLK_PERIOD_NS   = 20;
  localparam int unsigned SENSE_PERIOD_NS = 100000;  // spacing of overcurrent looks
  localparam int unsigned SENSE_WIN_NS    = 100;     // pin released this long per look
  // longest spacing rounds down, least window rounds up
  localparam int unsigned SENSE_PERIOD_CYC = SENSE_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned SENSE_WIN_CYC    = (SENSE_WIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SYNC_W           = 2 + 3 * PORT_CNT;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [PORT_CNT-1:0] STRAP_RST = 4'h0;
  localparam logic                GANG_RST  = 1'b0;

  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [2:0] {
    HPPSL_HOLD = 3'b001,  // in reset, pins released so straps can be read
    HPPSL_CAPT = 3'b010,  // one cycle to latch the straps
    HPPSL_RUN  = 3'b100
  } hppsl_state_e;

  // pin levels that cross into the clock domain
  typedef struct packed {
    logic                ext_rst_n;
    logic                up_pwr;
    logic [PORT_CNT-1:0] ctl_in;
    logic [PORT_CNT-1:0] dp;
    logic [PORT_CNT-1:0] dm;
  } hppsl_pins_s;

  typedef struct packed {
    hppsl_state_e        st;
    hppsl_pins_s         s1;
    hppsl_pins_s         s2;
    logic [PORT_CNT-1:0] dp_lat;
    logic [PORT_CNT-1:0] dm_lat;
    logic                gang_lat;
    logic [15:0]         sense_cnt;
    logic [3:0]          win_cnt;
    logic [PORT_CNT-1:0] oc;
    logic                attach;
    logic                up_prev;
    logic                reconnect;
  } hppsl_state_s;

endpackage

// File: hdl/hppsl_port_power.sv
`timescale 1ns/100ps
module hppsl_port_power
  import hppsl_pkg::*;
#(
  parameter int unsigned SENSE_PERIOD = SENSE_PERIOD_CYC,
  parameter int unsigned SENSE_WIN    = SENSE_WIN_CYC
) (
  // clock and power-on reset
  input  wire logic                mclk,
  input  wire logic                rst,
  // external reset pin
  input  wire logic                ext_reset_n,
  // configuration strap pins
  input  wire logic [PORT_CNT-1:0] port_dplus_disable_strap,
  input  wire logic [PORT_CNT-1:0] port_dminus_disable_strap,
  // port power control pins, bit 3 also carries shared_power_select
  input  wire logic [PORT_CNT-1:0] port_power_ctl_pin_in,
  output logic      [PORT_CNT-1:0] port_power_ctl_pin_out,
  output logic      [PORT_CNT-1:0] port_power_ctl_pin_oe,
  // upstream power detect pin
  input  wire logic                upstream_power_detect,
  // hub core side
  input  wire logic [PORT_CNT-1:0] port_power_req,
  input  wire logic [PORT_CNT-1:0] port_oc_clear,
  output logic      [PORT_CNT-1:0] port_disabled,
  output logic      [PORT_CNT-1:0] port_power_on,
  output logic      [PORT_CNT-1:0] port_overcurrent,
  output logic                     shared_power_select,
  output logic                     core_running,
  output logic                     upstream_attach,
  output logic                     upstream_reconnect
);

  // ************************************************************
  // state and derived terms
  // ************************************************************
  hppsl_state_s        cur_ff;
  hppsl_state_s        nxt_st;
  hppsl_pins_s         pins_now;
  logic                run;
  logic                sensing;
  logic                sample;
  logic                common_on;
  logic [PORT_CNT-1:0] want;
  logic [PORT_CNT-1:0] eff_on;
  logic [PORT_CNT-1:0] oc_seen;

  // gather pin levels for the synchroniser
  assign pins_now = '{ext_rst_n: ext_reset_n, up_pwr: upstream_power_detect,
                      ctl_in: port_power_ctl_pin_in,
                      dp: port_dplus_disable_strap, dm: port_dminus_disable_strap};

  assign run       = (cur_ff.st == HPPSL_RUN);
  assign sensing   = (cur_ff.win_cnt != 4'h0);
  assign sample    = (cur_ff.win_cnt == 4'h1);
  assign port_disabled = cur_ff.dp_lat & cur_ff.dm_lat;
  // a port wants power only while running, enabled and free of overcurrent
  assign want      = port_power_req & ~port_disabled & ~cur_ff.oc & {PORT_CNT{run}};
  assign common_on = |want;

  // ************************************************************
  // per-port pin drive
  // ************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < PORT_CNT; gi++) begin : g_port
      if (gi == PORT_CNT - 1) begin : g_last
        // the last pin is the common switch control in ganged mode
        assign eff_on[gi] = cur_ff.gang_lat ? common_on : want[gi];
        assign port_power_ctl_pin_oe[gi] = run & ~(sensing & eff_on[gi]);
      end else begin : g_rest
        assign eff_on[gi] = ~cur_ff.gang_lat & want[gi];
        // in ganged mode the other pins are left to their pull-ups
        assign port_power_ctl_pin_oe[gi] = run & ~cur_ff.gang_lat & ~(sensing & eff_on[gi]);
      end
      // high means power on; low removes power, also for disabled ports when not ganged
      assign port_power_ctl_pin_out[gi] = eff_on[gi] & ~sensing;
      // a released powered pin pulled low by the monitor is an overcurrent
      assign oc_seen[gi] = sample & eff_on[gi] & ~cur_ff.s2.ctl_in[gi];
    end
  endgenerate

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    nxt_st    = cur_ff;
    // first stage feeds the second stage only
    nxt_st.s1 = pins_now;
    nxt_st.s2 = cur_ff.s1;
    nxt_st.reconnect = 1'b0;
    case (cur_ff.st)
      HPPSL_HOLD: begin
        // pins are released here, so the synced strap levels are valid
        if (cur_ff.s2.ext_rst_n) begin
          nxt_st.st = HPPSL_CAPT;
        end
      end
      HPPSL_CAPT: begin
        nxt_st.dp_lat   = cur_ff.s2.dp;
        nxt_st.dm_lat   = cur_ff.s2.dm;
        nxt_st.gang_lat = cur_ff.s2.ctl_in[PORT_CNT-1];
        nxt_st.oc       = '0;
        nxt_st.sense_cnt = 16'(SENSE_PERIOD - 1);
        nxt_st.win_cnt  = 4'h0;
        nxt_st.st       = HPPSL_RUN;
      end
      HPPSL_RUN: begin
        // overcurrent look: release powered pins, sample at end of window
        if (sensing) begin
          nxt_st.win_cnt = cur_ff.win_cnt - 4'h1;
        end else if (cur_ff.sense_cnt == 16'h0) begin
          nxt_st.win_cnt   = 4'(SENSE_WIN);
          nxt_st.sense_cnt = 16'(SENSE_PERIOD - 1);
        end else begin
          nxt_st.sense_cnt = cur_ff.sense_cnt - 16'h1;
        end
        // a new overcurrent wins over a clear in the same cycle
        if (cur_ff.gang_lat) begin
          nxt_st.oc = ((cur_ff.oc & ~port_oc_clear)
                      | {PORT_CNT{oc_seen[PORT_CNT-1]}}) & ~port_disabled;
        end else begin
          nxt_st.oc = ((cur_ff.oc & ~port_oc_clear) | oc_seen) & ~port_disabled;
        end
        if (!cur_ff.s2.ext_rst_n) begin
          // straps stay latched through the external reset
          nxt_st.st = HPPSL_HOLD;
        end
      end
      default: begin
        nxt_st.st = HPPSL_HOLD;
      end
    endcase
    // upstream presence follows the detect pin; a rise means reconnect
    nxt_st.up_prev   = cur_ff.s2.up_pwr;
    nxt_st.attach    = (nxt_st.st == HPPSL_RUN) & cur_ff.s2.up_pwr;
    nxt_st.reconnect = run & cur_ff.s2.up_pwr & ~cur_ff.up_prev;
  end

  // state register; the power-on reset forces a new strap capture
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cur_ff <= '{st: HPPSL_HOLD, dp_lat: STRAP_RST, dm_lat: STRAP_RST,
                 gang_lat: GANG_RST, default: '0};
    end else begin
      cur_ff <= nxt_st;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign port_power_on       = eff_on;
  assign port_overcurrent    = cur_ff.oc;
  assign shared_power_select = cur_ff.gang_lat;
  assign core_running        = run;
  assign upstream_attach     = cur_ff.attach;
  assign upstream_reconnect  = cur_ff.reconnect;

  // ************************************************************
  // assertions
  // ************************************************************
  AST_STRAP_HOLD: assert property (@(posedge mclk) disable iff (rst)
    (cur_ff.st != HPPSL_CAPT) |=> $stable(cur_ff.dp_lat) && $stable(cur_ff.gang_lat))
    else $error("straps changed outside a capture");

  AST_STRAP_TAKE: assert property (@(posedge mclk) disable iff (rst)
    (cur_ff.st == HPPSL_CAPT) |=> cur_ff.dm_lat == $past(cur_ff.s2.dm) && run)
    else $error("straps not taken at capture");

  AST_DIS_EVAL: assert property (@(posedge mclk) disable iff (rst)
    (cur_ff.st == HPPSL_CAPT) |=>
      port_disabled == ($past(cur_ff.s2.dp) & $past(cur_ff.s2.dm)))
    else $error("disable not formed from both straps");

  AST_PWR_HIGH: assert property (@(posedge mclk) disable iff (rst)
    (run && !cur_ff.gang_lat && !sensing && want[0]) |->
      port_power_ctl_pin_oe[0] && port_power_ctl_pin_out[0])
    else $error("enabled port pin not driven high");

  AST_OC_SET: assert property (@(posedge mclk) disable iff (rst)
    (run && !cur_ff.gang_lat && oc_seen[1] && !port_disabled[1]) |=> port_overcurrent[1] ##1
      !port_power_on[1])
    else $error("overcurrent not latched or power kept");

  AST_GANG_PINS: assert property (@(posedge mclk) disable iff (rst)
    (run && cur_ff.gang_lat) |-> port_power_ctl_pin_oe[PORT_CNT-2:0] == '0)
    else $error("ganged mode drives a non-common pin");

  AST_ATTACH: assert property (@(posedge mclk) disable iff (rst)
    (run && $past(run)) |-> upstream_attach == $past(cur_ff.s2.up_pwr))
    else $error("attach does not follow power detect");

  AST_RECONNECT: assert property (@(posedge mclk) disable iff (rst)
    (run && $rose(cur_ff.s2.up_pwr) && cur_ff.s2.ext_rst_n) |=>
      upstream_reconnect && run && $stable(cur_ff.dp_lat))
    else $error("detect toggle did not renegotiate in place");

  AST_DIS_OFF: assert property (@(posedge mclk) disable iff (rst)
    (port_disabled & (port_power_on | port_overcurrent)) == '0)
    else $error("disabled port powered or flagged");

  AST_PIN_LOW: assert property (@(posedge mclk) disable iff (rst)
    (run && !cur_ff.gang_lat && !want[1]) |->
      port_power_ctl_pin_oe[1] && !port_power_ctl_pin_out[1])
    else $error("unpowered port pin not driven low");

  AST_PINS_FREE: assert property (@(posedge mclk) disable iff (rst)
    !run |-> port_power_ctl_pin_oe == '0 && port_power_ctl_pin_out == '0)
    else $error("control pin driven while straps are read");

  AST_GANG_OC: assert property (@(posedge mclk) disable iff (rst)
    (run && cur_ff.gang_lat && oc_seen[PORT_CNT-1]) |=>
      port_overcurrent == ~port_disabled)
    else $error("common pin overcurrent not spread to enabled ports");

  AST_OC_CLEAR: assert property (@(posedge mclk) disable iff (rst)
    (run && !cur_ff.gang_lat && port_oc_clear[1] && !oc_seen[1]) |=>
      !port_overcurrent[1])
    else $error("overcurrent flag not cleared");

endmodule // hppsl_port_power

// File: dv/hppsl_switch_model.sv
`timescale 1ns/100ps
module hppsl_switch_model
  import hppsl_pkg::*;
(
  // hub drive on the control pins
  input  wire logic [PORT_CNT-1:0] pin_out,
  input  wire logic [PORT_CNT-1:0] pin_oe,
  // bench controls: monitor faults, low strap resistor on port 4
  input  wire logic [PORT_CNT-1:0] fault,
  input  wire logic                strap_low,
  // resolved pin level
  output logic      [PORT_CNT-1:0] pin_level
);
  // ****************************************************
  // pin resolution
  // ****************************************************
  // released pins float to the pull-up unless something pulls low
  always_comb begin
    for (int i = 0; i < PORT_CNT; i++) begin
      if (pin_oe[i]) begin
        pin_level[i] = pin_out[i];
      end else begin
        pin_level[i] = ~fault[i];
      end
    end
    // strap resistor is weaker than the hub drive
    if (!pin_oe[3] && strap_low) begin
      pin_level[3] = 1'b0;
    end
  end
endmodule  // hppsl_switch_model

// File: dv/tb_hppsl_port_power.sv
`timescale 1ns/100ps
module tb_hppsl_port_power;
  import hppsl_pkg::*;
  // ****************************************************
  // stimulus, results, rows of {dplus, dminus, disabled}
  // ****************************************************
  logic       mclk = 0, rst = 1, ext_n = 1, up = 0, sl = 1;
  logic [3:0] dp = 0, dm = 0, req = 0, clr = 0, flt = 0, lvl;
  logic [3:0] oe, out, dis, pon, oc;
  logic       sps, run, att, rcn;
  int         miscompares = 0, check_count = 0, cyc = 0;
  logic [11:0] rows [5] = '{12'hf00, 12'h0f0, 12'h531, 12'hfff, 12'h6c4};

  hppsl_port_power #(.SENSE_PERIOD(20), .SENSE_WIN(5)) u_dut (
    .mclk(mclk), .rst(rst), .ext_reset_n(ext_n),
    .port_dplus_disable_strap(dp), .port_dminus_disable_strap(dm),
    .port_power_ctl_pin_in(lvl), .port_power_ctl_pin_out(out), .port_power_ctl_pin_oe(oe),
    .upstream_power_detect(up), .port_power_req(req), .port_oc_clear(clr),
    .port_disabled(dis), .port_power_on(pon), .port_overcurrent(oc),
    .shared_power_select(sps), .core_running(run), .upstream_attach(att),
    .upstream_reconnect(rcn));
  hppsl_switch_model u_sw (.pin_out(out), .pin_oe(oe), .fault(flt), .strap_low(sl),
    .pin_level(lvl));

  initial forever #10 mclk = ~mclk;
  // hang guard: far above the few hundred cycles the run needs
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      miscompares++;
      print_verdict();
    end
  end

  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // wait for capture to finish, then lift the port 4 strap resistor
  task automatic wait_run;
    int n;
    n = 0;
    while (run !== 1'b1 && n < 20) begin
      @(negedge mclk);
      n++;
    end
    if (n == 20) miscompares++;
    sl = 0;
  endtask
  task automatic restart(input logic gang);
    sl = ~gang;
    @(negedge mclk) ext_n = 0;
    repeat (4) @(negedge mclk);
    ext_n = 1;
    wait_run();
  endtask
  task automatic print_verdict;
    if (miscompares == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // ****************************************************
  // main sequence
  // ****************************************************
  initial begin
    repeat (6) @(negedge mclk);
    chk(oe, 4'h0);
    rst = 0;
    wait_run();
    foreach (rows[i]) begin
      {dp, dm} = rows[i][11:4];
      restart(1'b0);
      req = 4'hf;
      @(negedge mclk);
      chk(dis, rows[i][3:0]);
      chk(pon, ~rows[i][3:0]);
      chk(out & oe, oe & ~rows[i][3:0]);
      chk({3'h0, sps}, 4'h0);
      req = 0;
    end
    // strap moves while running are ignored, power-on reset recaptures
    {dp, dm} = 8'h00;
    repeat (5) @(negedge mclk);
    chk(dis, 4'h4);
    rst = 1;
    sl = 1;
    @(negedge mclk) rst = 0;
    wait_run();
    chk(dis, 4'h0);
    // faults on an enabled and a disabled port
    {dp, dm} = 8'h11;
    restart(1'b0);
    req = 4'hf;
    flt = 4'h3;
    repeat (50) @(negedge mclk);
    chk(oc, 4'h2);
    chk(pon, 4'hc);
    flt = 0;
    clr = 4'hf;
    @(negedge mclk) clr = 0;
    chk(oc, 4'h0);
    // ganged mode: port 4 pin is the common control and sense
    {dp, dm} = 8'h00;
    restart(1'b1);
    req = 4'h2;
    @(negedge mclk);
    chk({3'h0, sps}, 4'h1);
    chk(pon, 4'h8);
    chk(oe & 4'h7, 4'h0);
    flt = 4'h8;
    repeat (50) @(negedge mclk);
    chk(oc, 4'hf);
    flt = 0;
    // upstream detect toggled by the host
    @(negedge mclk) up = 1;
    repeat (3) @(posedge mclk);
    #1 chk({2'h0, att, rcn}, 4'h3);
    @(posedge mclk);
    #1 chk({2'h0, att, rcn}, 4'h2);
    @(negedge mclk) up = 0;
    repeat (3) @(posedge mclk);
    #1 chk({1'b0, run, att, rcn}, 4'h4);
    print_verdict();
  end
endmodule  // tb_hppsl_port_power
